/* hdl/er3_pkg.sv */
/*
 Shared types and constants for the third-regulator control block.
 Assumes the system mode code comes from the mode controller on ref_clk.
*/
package er3_pkg;

	// System operating modes; codes 6 and 7 are illegal
	typedef enum logic [2:0]
	{
		ER3_MODE_INIT = 3'h0,
		ER3_MODE_NORMAL = 3'h1,
		ER3_MODE_STOP = 3'h2,
		ER3_MODE_SLEEP = 3'h3,
		ER3_MODE_RESTART = 3'h4,
		ER3_MODE_FAILSAFE = 3'h5
	} er3_mode_e;

	// Locked configuration of the third regulator
	typedef enum logic [1:0]
	{
		ER3_CFG_NONE = 2'h0,
		ER3_CFG_STANDALONE = 2'h1,
		ER3_CFG_LOADSHARE = 2'h2
	} er3_cfg_e;

	// Pin-side status vector bit positions
	localparam int ER3_PIN_BATT_UV = 0;
	localparam int ER3_PIN_SHUNT = 1;
	localparam int ER3_PIN_REG_UV = 2;
	localparam int ER3_PIN_BASE_HI = 3;
	localparam int ER3_PIN_BASE_LO = 4;
	localparam int ER3_PIN_COUNT = 5;

	// Reset value and minimum synchroniser depth
	localparam logic ER3_RST_BIT = 1'b0;
	localparam int ER3_SYNC_STAGES_MIN = 2;

endpackage : er3_pkg

/* hdl/er3_regulator_control.sv */
/*
 Control logic for the third supply regulator with an external pass
 transistor: configuration lock, voltage select, enable per system mode,
 supply undervoltage reaction, high-power stage and status flags.
 Assumes control inputs come from the serial control port logic on ref_clk
 and that analog comparator outputs arrive asynchronously on pins.
*/
`timescale 1ns/1ns
module er3_regulator_control
#(
	parameter int SYNC_STAGES = 2
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic softReset,
	input wire er3_pkg::er3_mode_e sbcMode,
	input wire logic cfgWrite,
	input wire logic wrStandaloneOn,
	input wire logic wrLoadShare,
	input wire logic reg3VoltageSelect,
	input wire logic reg3StayOffAfterSupplyUv,
	input wire logic loadShareStopKeepOn,
	input wire logic ocFlagClear,
	input wire logic uvFlagClear,
	input wire logic batteryUndervoltagePin,
	input wire logic shuntLimitPin,
	input wire logic reg3UndervoltagePin,
	input wire logic baseAboveUpperPin,
	input wire logic baseBelowLowerPin,
	output er3_pkg::er3_cfg_e reg3Config_r,
	output logic reg3StandaloneOn_r,
	output logic passTransistorBaseDrive_r,
	output logic reg3Select3v3_r,
	output logic highPowerStage_r,
	output logic currentLimit_r,
	output logic reg3OvercurrentFlag_r,
	output logic reg3UndervoltageFlag_r,
	output logic spiFail_r
);
	import er3_pkg::*;

	if (SYNC_STAGES < ER3_SYNC_STAGES_MIN)
	begin : g_badSyncStages
		$error("SYNC_STAGES must be at least 2");
	end

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [ER3_PIN_COUNT-1:0] pinMeta_r;
	logic [ER3_PIN_COUNT-1:0] pinSync_r [SYNC_STAGES-1];
	logic [ER3_PIN_COUNT-1:0] pinS;
	logic battUvS;
	logic shuntS;
	logic regUvS;
	logic baseHiS;
	logic baseLoS;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinMeta_r <= '0;
			for (int i = 0; i < SYNC_STAGES - 1; i++)
				pinSync_r[i] <= '0;
		end
		else
		begin
			pinMeta_r <= {baseBelowLowerPin, baseAboveUpperPin,
				reg3UndervoltagePin, shuntLimitPin, batteryUndervoltagePin};
			pinSync_r[0] <= pinMeta_r;
			for (int i = 1; i < SYNC_STAGES - 1; i++)
				pinSync_r[i] <= pinSync_r[i-1];
		end
	end

	assign pinS = pinSync_r[SYNC_STAGES-2];
	assign battUvS = pinS[ER3_PIN_BATT_UV];
	assign shuntS = pinS[ER3_PIN_SHUNT];
	assign regUvS = pinS[ER3_PIN_REG_UV];
	assign baseHiS = pinS[ER3_PIN_BASE_HI];
	assign baseLoS = pinS[ER3_PIN_BASE_LO];

	// ==========================================================
	// Configuration lock and regulator-on bit
	// ==========================================================
	function automatic logic isNormal(input er3_mode_e m);
		return m == ER3_MODE_NORMAL;
	endfunction : isNormal

	logic isStandalone;
	logic isLoadShare;
	logic onWriteOk;
	assign isStandalone = reg3Config_r == ER3_CFG_STANDALONE;
	assign isLoadShare = reg3Config_r == ER3_CFG_LOADSHARE;
	assign onWriteOk = cfgWrite && isNormal(sbcMode) && (isStandalone ||
		(reg3Config_r == ER3_CFG_NONE && !wrLoadShare));

	// Only power-on reset unlocks; soft reset leaves the choice alone
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			reg3Config_r <= ER3_CFG_NONE;
		else if (cfgWrite && reg3Config_r == ER3_CFG_NONE)
		begin
			if (wrLoadShare)
				reg3Config_r <= ER3_CFG_LOADSHARE;
			else if (wrStandaloneOn && isNormal(sbcMode))
				reg3Config_r <= ER3_CFG_STANDALONE;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			reg3StandaloneOn_r <= ER3_RST_BIT;
		else if (softReset)
			reg3StandaloneOn_r <= ER3_RST_BIT;
		else if (onWriteOk)
			reg3StandaloneOn_r <= wrStandaloneOn;
	end

	// Fail only for a change attempt on a locked load-share setup
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			spiFail_r <= ER3_RST_BIT;
		else
			spiFail_r <= cfgWrite && isLoadShare &&
				(wrStandaloneOn || !wrLoadShare);
	end

	// ==========================================================
	// Enable per mode and supply undervoltage
	// ==========================================================
	logic uvHoldOff_r;
	logic modeOn;
	logic enableNxt;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			uvHoldOff_r <= ER3_RST_BIT;
		else if (battUvS && reg3StayOffAfterSupplyUv)
			uvHoldOff_r <= 1'b1;
		else if (!battUvS && cfgWrite && isNormal(sbcMode))
			uvHoldOff_r <= 1'b0;
	end

	always_comb
	begin
		modeOn = 1'b0;
		if (isStandalone)
		begin
			unique case (sbcMode)
				ER3_MODE_NORMAL, ER3_MODE_STOP, ER3_MODE_SLEEP,
				ER3_MODE_RESTART: modeOn = reg3StandaloneOn_r;
				default: modeOn = 1'b0;
			endcase
		end
		else if (isLoadShare)
		begin
			unique case (sbcMode)
				ER3_MODE_NORMAL: modeOn = 1'b1;
				ER3_MODE_STOP: modeOn = loadShareStopKeepOn;
				ER3_MODE_RESTART: modeOn = 1'b1;
				default: modeOn = 1'b0;
			endcase
		end
		enableNxt = modeOn && !battUvS && !uvHoldOff_r;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			passTransistorBaseDrive_r <= ER3_RST_BIT;
		else
			passTransistorBaseDrive_r <= enableNxt;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			reg3Select3v3_r <= ER3_RST_BIT;
		else
			reg3Select3v3_r <= isStandalone && reg3VoltageSelect;
	end

	// ==========================================================
	// High-power stage
	// ==========================================================
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			highPowerStage_r <= ER3_RST_BIT;
		else if (!enableNxt)
			highPowerStage_r <= 1'b0;
		else if (sbcMode == ER3_MODE_STOP)
		begin
			if (baseHiS)
				highPowerStage_r <= 1'b1;
			else if (baseLoS)
				highPowerStage_r <= 1'b0;
		end
		else
			highPowerStage_r <= 1'b1;
	end

	// ==========================================================
	// Current limit and status flags
	// ==========================================================
	logic ocEvent;
	logic uvEvent;
	assign ocEvent = isStandalone && passTransistorBaseDrive_r && shuntS;
	assign uvEvent = isStandalone && passTransistorBaseDrive_r && regUvS;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			currentLimit_r <= ER3_RST_BIT;
		else
			currentLimit_r <= ocEvent;
	end

	// Set wins over clear; ocFlagClear acts only once the condition is gone, softReset does not wait
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			reg3OvercurrentFlag_r <= ER3_RST_BIT;
		else if (ocEvent)
			reg3OvercurrentFlag_r <= 1'b1;
		else if (softReset || (ocFlagClear && !shuntS))
			reg3OvercurrentFlag_r <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			reg3UndervoltageFlag_r <= ER3_RST_BIT;
		else if (uvEvent)
			reg3UndervoltageFlag_r <= 1'b1;
		else if (softReset || uvFlagClear)
			reg3UndervoltageFlag_r <= 1'b0;
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_lsChangeTry;
		cfgWrite && isLoadShare && (wrStandaloneOn || !wrLoadShare);
	endsequence
	sequence s_saChangeTry;
		cfgWrite && isStandalone && wrLoadShare;
	endsequence

	property p_lockHold;
		reg3Config_r != ER3_CFG_NONE |=> reg3Config_r == $past(reg3Config_r);
	endproperty
	a_lockHold: assert property (p_lockHold)
		else $error("locked configuration changed");

	property p_lsFail;
		s_lsChangeTry |=> spiFail_r ##1 (!spiFail_r || $past(cfgWrite));
	endproperty
	a_lsFail: assert property (p_lsFail)
		else $error("fail flag missing on load-share change");

	property p_saNoFail;
		s_saChangeTry |=> !spiFail_r && isStandalone;
	endproperty
	a_saNoFail: assert property (p_saNoFail)
		else $error("stand-alone change not silently ignored");

	property p_vsel;
		isStandalone |=> reg3Select3v3_r == $past(reg3VoltageSelect);
	endproperty
	a_vsel: assert property (p_vsel)
		else $error("voltage select not followed");

	property p_vselIgnored;
		isLoadShare |=> !reg3Select3v3_r;
	endproperty
	a_vselIgnored: assert property (p_vselIgnored)
		else $error("voltage select used in load sharing");

	property p_offModes;
		(sbcMode == ER3_MODE_INIT || sbcMode == ER3_MODE_FAILSAFE)
			|=> !passTransistorBaseDrive_r;
	endproperty
	a_offModes: assert property (p_offModes)
		else $error("regulator on in init or fail-safe");

	property p_stopLs;
		isLoadShare && sbcMode == ER3_MODE_STOP && !loadShareStopKeepOn
			|=> !passTransistorBaseDrive_r;
	endproperty
	a_stopLs: assert property (p_stopLs)
		else $error("load sharing kept on in stop");

	property p_normLs;
		isLoadShare && isNormal(sbcMode) && !battUvS && !uvHoldOff_r
			|=> passTransistorBaseDrive_r;
	endproperty
	a_normLs: assert property (p_normLs)
		else $error("load sharing not restored in normal");

	property p_battUv;
		battUvS |=> !passTransistorBaseDrive_r;
	endproperty
	a_battUv: assert property (p_battUv)
		else $error("regulator on during supply undervoltage");

	property p_lsNoOc;
		isLoadShare |-> !reg3OvercurrentFlag_r && !currentLimit_r &&
			!reg3UndervoltageFlag_r;
	endproperty
	a_lsNoOc: assert property (p_lsNoOc)
		else $error("flag raised in load sharing");

	property p_ocSet;
		ocEvent |=> reg3OvercurrentFlag_r && currentLimit_r;
	endproperty
	a_ocSet: assert property (p_ocSet)
		else $error("overcurrent not flagged");

	property p_uvSet;
		uvEvent |=> reg3UndervoltageFlag_r;
	endproperty
	a_uvSet: assert property (p_uvSet)
		else $error("undervoltage not flagged");

	property p_hpNormal;
		isNormal(sbcMode) && enableNxt |=> highPowerStage_r;
	endproperty
	a_hpNormal: assert property (p_hpNormal)
		else $error("high-power stage off in normal");

endmodule : er3_regulator_control

/* test/er3_pnp_model.sv */
/*
 Behavioural model of the external pass transistor and its shunt.
 Assumes the bench sets load level and output undervoltage injection.
*/
`timescale 1ns/1ns
module er3_pnp_model
#(
	parameter int LAG = 1
)
(
	input wire logic ref_clk,
	input wire logic baseDrive,
	input wire logic [1:0] load,
	input wire logic outUv,
	output logic shunt,
	output logic regUv,
	output logic baseHi,
	output logic baseLo
);
	logic [3:0] now;
	logic [3:0] dly [4];
	logic busy;
	// Comparators only see current while the base is driven
	assign busy = baseDrive && load != 2'h0;
	assign now = {baseDrive && load == 2'h2, baseDrive && outUv, busy, !busy};
	always_ff @(posedge ref_clk)
	begin
		dly[0] <= now;
		for (int i = 1; i < 4; i++)
			dly[i] <= dly[i - 1];
	end
	assign {shunt, regUv, baseHi, baseLo} = (LAG == 0) ? now : dly[LAG - 1];
endmodule : er3_pnp_model

/* test/er3_regulator_control_tb.sv */
/*
 Self-checking bench for the third-regulator control block.
 Assumes the pass transistor model sits on the pin side.
*/
`timescale 1ns/1ns
module er3_regulator_control_tb;
	import er3_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic softReset = 1'b0;
	er3_mode_e sbcMode = ER3_MODE_INIT;
	logic cfgWrite = 1'b0;
	logic wrOn = 1'b0;
	logic wrLs = 1'b0;
	logic vSel = 1'b0;
	logic stayOff = 1'b0;
	logic keepOn = 1'b0;
	logic ocClr = 1'b0;
	logic uvClr = 1'b0;
	logic battUv = 1'b0;
	logic [1:0] load = 2'h0;
	logic outUv = 1'b0;
	logic shunt, regUv, baseHi, baseLo;
	er3_cfg_e cfg;
	logic on, drive, sel, hp, lim, ocF, uvF, fail;
	int badCount = 0;
	int nChecks = 0;
	always #2 ref_clk = ~ref_clk;
	er3_regulator_control uut
	(
		.ref_clk(ref_clk), .resetn(resetn), .softReset(softReset),
		.sbcMode(sbcMode), .cfgWrite(cfgWrite), .wrStandaloneOn(wrOn),
		.wrLoadShare(wrLs), .reg3VoltageSelect(vSel),
		.reg3StayOffAfterSupplyUv(stayOff), .loadShareStopKeepOn(keepOn),
		.ocFlagClear(ocClr), .uvFlagClear(uvClr),
		.batteryUndervoltagePin(battUv), .shuntLimitPin(shunt),
		.reg3UndervoltagePin(regUv), .baseAboveUpperPin(baseHi),
		.baseBelowLowerPin(baseLo), .reg3Config_r(cfg),
		.reg3StandaloneOn_r(on), .passTransistorBaseDrive_r(drive),
		.reg3Select3v3_r(sel), .highPowerStage_r(hp),
		.currentLimit_r(lim), .reg3OvercurrentFlag_r(ocF),
		.reg3UndervoltageFlag_r(uvF), .spiFail_r(fail)
	);
	er3_pnp_model pnp
	(
		.ref_clk(ref_clk), .baseDrive(drive), .load(load), .outUv(outUv),
		.shunt(shunt), .regUv(regUv), .baseHi(baseHi), .baseLo(baseLo)
	);
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : step
	task automatic chk(input string name, input logic seen, input logic exp);
		nChecks++;
		if (seen !== exp)
		begin
			badCount++;
			$display("Error %s expected %b seen %b", name, exp, seen);
		end
	endtask : chk
	task automatic finishTest;
		$display("checks %0d errors %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finishTest
	task automatic wr(input logic o, input logic l);
		cfgWrite = 1'b1;
		wrOn = o;
		wrLs = l;
		step(1);
		cfgWrite = 1'b0;
	endtask : wr
	task automatic ckCfg(input er3_cfg_e e);
		chk("cfg0", cfg[0], e[0]);
		chk("cfg1", cfg[1], e[1]);
	endtask : ckCfg
	task automatic md(input er3_mode_e m, input logic e);
		sbcMode = m;
		step(2);
		chk("drive", drive, e);
	endtask : md
	initial
	begin
		#40000;
		badCount++;
		finishTest();
	end
	initial
	begin
		step(20);
		resetn = 1'b1;
		ckCfg(ER3_CFG_NONE);
		sbcMode = ER3_MODE_NORMAL;
		step(1);
		wr(1'b1, 1'b0);
		ckCfg(ER3_CFG_STANDALONE);
		chk("on", on, 1'b1);
		step(1);
		chk("drive", drive, 1'b1);
		chk("hp", hp, 1'b1);
		chk("sel", sel, 1'b0);
		vSel = 1'b1;
		step(2);
		chk("sel", sel, 1'b1);
		wr(1'b0, 1'b1);
		ckCfg(ER3_CFG_STANDALONE);
		chk("fail", fail, 1'b0);
		step(1);
		chk("drive", drive, 1'b0);
		wr(1'b1, 1'b0);
		step(1);
		chk("drive", drive, 1'b1);
		md(ER3_MODE_STOP, 1'b1);
		md(ER3_MODE_SLEEP, 1'b1);
		md(ER3_MODE_RESTART, 1'b1);
		md(ER3_MODE_INIT, 1'b0);
		md(ER3_MODE_FAILSAFE, 1'b0);
		md(er3_mode_e'(3'h6), 1'b0);
		md(ER3_MODE_STOP, 1'b1);
		load = 2'h1;
		step(6);
		chk("hp", hp, 1'b1);
		load = 2'h0;
		step(6);
		chk("hp", hp, 1'b0);
		md(ER3_MODE_NORMAL, 1'b1);
		chk("hp", hp, 1'b1);
		load = 2'h2;
		step(6);
		chk("oc", ocF, 1'b1);
		chk("lim", lim, 1'b1);
		chk("drive", drive, 1'b1);
		ocClr = 1'b1;
		step(1);
		ocClr = 1'b0;
		chk("oc", ocF, 1'b1);
		load = 2'h0;
		step(6);
		chk("lim", lim, 1'b0);
		ocClr = 1'b1;
		step(1);
		ocClr = 1'b0;
		step(1);
		chk("oc", ocF, 1'b0);
		outUv = 1'b1;
		step(6);
		chk("uv", uvF, 1'b1);
		outUv = 1'b0;
		// Let the synchronised condition drop before clearing
		step(4);
		uvClr = 1'b1;
		step(1);
		uvClr = 1'b0;
		step(1);
		chk("uv", uvF, 1'b0);
		battUv = 1'b1;
		step(5);
		chk("drive", drive, 1'b0);
		battUv = 1'b0;
		step(5);
		chk("drive", drive, 1'b1);
		stayOff = 1'b1;
		battUv = 1'b1;
		step(5);
		battUv = 1'b0;
		step(5);
		chk("drive", drive, 1'b0);
		wr(1'b1, 1'b0);
		step(1);
		chk("drive", drive, 1'b1);
		stayOff = 1'b0;
		softReset = 1'b1;
		step(1);
		softReset = 1'b0;
		ckCfg(ER3_CFG_STANDALONE);
		chk("on", on, 1'b0);
		wr(1'b0, 1'b1);
		ckCfg(ER3_CFG_STANDALONE);
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		ckCfg(ER3_CFG_NONE);
		wr(1'b0, 1'b1);
		ckCfg(ER3_CFG_LOADSHARE);
		step(1);
		chk("drive", drive, 1'b1);
		chk("sel", sel, 1'b0);
		wr(1'b1, 1'b1);
		chk("fail", fail, 1'b1);
		ckCfg(ER3_CFG_LOADSHARE);
		step(1);
		chk("fail", fail, 1'b0);
		wr(1'b0, 1'b0);
		chk("fail", fail, 1'b1);
		ckCfg(ER3_CFG_LOADSHARE);
		md(ER3_MODE_STOP, 1'b0);
		md(ER3_MODE_SLEEP, 1'b0);
		md(ER3_MODE_RESTART, 1'b1);
		md(ER3_MODE_FAILSAFE, 1'b0);
		md(ER3_MODE_INIT, 1'b0);
		md(ER3_MODE_NORMAL, 1'b1);
		keepOn = 1'b1;
		md(ER3_MODE_STOP, 1'b1);
		md(ER3_MODE_NORMAL, 1'b1);
		load = 2'h2;
		outUv = 1'b1;
		step(6);
		chk("oc", ocF, 1'b0);
		chk("lim", lim, 1'b0);
		chk("uv", uvF, 1'b0);
		battUv = 1'b1;
		step(5);
		chk("drive", drive, 1'b0);
		finishTest();
	end
endmodule : er3_regulator_control_tb
